// ===== bbsr_bus_model.sv
// far-side model of the two parallel buses
`timescale 1ns/10ps
`default_nettype none
module bbsr_bus_model (
    input  wire logic       a_oe_i,
    input  wire logic [7:0] a_dev_i,
    input  wire logic [7:0] a_ext_i,
    input  wire logic       b_oe_i,
    input  wire logic [7:0] b_dev_i,
    input  wire logic [7:0] b_ext_i,
    output logic      [7:0] a_bus_o,
    output logic      [7:0] b_bus_o
);
    // outside logic drives a side only while the device releases it
    assign a_bus_o = a_oe_i ? a_dev_i : a_ext_i;
    assign b_bus_o = b_oe_i ? b_dev_i : b_ext_i;
endmodule
`default_nettype wire

// ===== bbsr_fifo.sv
// shifting fifo with the head word held in a flip-flop
`timescale 1ns/10ps
`default_nettype none
module bbsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [CW-1:0]    count_ff;
    logic [CW-1:0]    nxt_count;
    logic             valid_ff;
    logic             push;
    logic             pop;

    assign in_ready_o = (count_ff != CW'(DEPTH));
    assign push       = in_valid_i && in_ready_o;
    assign pop        = valid_ff && out_ready_i;

    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + CW'(1);
        end else if (pop && !push) begin
            nxt_count = count_ff - CW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            valid_ff <= (nxt_count != '0);
        end
    end

    // entries move one place toward the head on each pop
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (pop) begin
                    if (push && (CW'(i) == count_ff - CW'(1))) begin
                        mem_ff[i] <= in_data_i;
                    end else if (i < DEPTH - 1) begin
                        mem_ff[i] <= mem_ff[i+1];
                    end
                end else if (push && (CW'(i) == count_ff)) begin
                    mem_ff[i] <= in_data_i;
                end
            end
        end
    end

    assign out_valid_o = valid_ff;
    assign out_data_o  = mem_ff[0];
endmodule
`default_nettype wire

// ===== bbsr_pkg.sv
// types and mode decode of the bidirectional bus shift register
`default_nettype none
package bbsr_pkg;

    typedef enum logic [1:0] {
        MODE_SERIAL,
        MODE_PAR_CLOCKED,
        MODE_PAR_FOLLOW
    } bbsr_mode_t;

    // asynchronous select only counts in parallel mode
    function automatic bbsr_mode_t bbsr_decode_mode(input logic par_sel, input logic async_sel);
        if (!par_sel) begin
            return MODE_SERIAL;
        end
        return async_sel ? MODE_PAR_FOLLOW : MODE_PAR_CLOCKED;
    endfunction

endpackage
`default_nettype wire

// ===== bbsr_regs.svh
// constants of the bidirectional bus shift register
`ifndef BBSR_REGS_SVH
`define BBSR_REGS_SVH

`define BBSR_WIDTH      8
`define BBSR_LAST_STAGE 7
`define BBSR_RESET_VAL  8'h00
`define BBSR_FIFO_DEPTH 16
`define BBSR_SYNC_W     22

`endif

// ===== bbsr_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
`default_nettype none
module bbsr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule
`default_nettype wire

// ===== bbsr_top.sv
// eight-stage register between two parallel buses with serial input
// Function
// - serial mode shifts on clock, ignores async select
// - serial, direction low, enable low: A floats
// - serial, direction low, enable high: drive A
// - serial, direction high: drive B always
// - parallel B clocked load, A floats
// - parallel B follow load, A floats
// - direction high, enable low, clocked: recirculate, drive B
// - direction high, enable low, async: hold, drive B
// - enable high: clocked B load, drive A
// - enable high: follow B load, drive A
// - enable, direction high: clocked A load, drive B
// - all high: follow A load, drive B
`timescale 1ns/10ps
`default_nettype none
`include "bbsr_regs.svh"
module bbsr_top (
    input  wire logic                   CLK_SYS_I,
    input  wire logic                   RESET_N_I,
    input  wire logic                   SHIFT_CLK_I,
    input  wire logic                   SER_DATA_I,
    input  wire logic                   PAR_SER_SEL_I,
    input  wire logic                   DIR_SEL_I,
    input  wire logic                   ASYNC_SEL_I,
    input  wire logic                   SIDE_A_DRIVE_ENABLE_I,
    input  wire logic [`BBSR_WIDTH-1:0] A_DATA_I,
    output logic      [`BBSR_WIDTH-1:0] A_DATA_O,
    output logic                        A_OE_O,
    input  wire logic [`BBSR_WIDTH-1:0] B_DATA_I,
    output logic      [`BBSR_WIDTH-1:0] B_DATA_O,
    output logic                        B_OE_O,
    output logic                        SER_OUT_O,
    output logic      [`BBSR_WIDTH-1:0] SNAP_DATA_O,
    output logic                        SNAP_VALID_O,
    input  wire logic                   SNAP_READY_I
);
    logic [`BBSR_SYNC_W-1:0] pins_s;
    logic                    clk_s;
    logic                    ser_s;
    logic                    par_s;
    logic                    dir_s;
    logic                    as_s;
    logic                    a_en_s;
    logic [`BBSR_WIDTH-1:0]  a_s;
    logic [`BBSR_WIDTH-1:0]  b_s;

    logic                    clk_d_ff;
    logic                    pend_ff;
    logic [`BBSR_WIDTH-1:0]  stage_ff;
    logic [`BBSR_WIDTH-1:0]  nxt_stage;
    logic [`BBSR_WIDTH-1:0]  par_src;
    logic                    a_oe_ff;
    logic                    b_oe_ff;
    logic                    edge_any;
    logic                    clocked;
    logic                    go;
    logic                    fifo_ready;
    bbsr_pkg::bbsr_mode_t    mode;

    // every pin level except RESET_N_I and SNAP_READY_I passes two flops before use
    bbsr_sync #(
        .W         (`BBSR_SYNC_W)
    ) u_sync (
        .clk_i     (CLK_SYS_I),
        .reset_n_i (RESET_N_I),
        .d_i       ({SHIFT_CLK_I, SER_DATA_I, PAR_SER_SEL_I, DIR_SEL_I,
                     ASYNC_SEL_I, SIDE_A_DRIVE_ENABLE_I, A_DATA_I, B_DATA_I}),
        .q_o       (pins_s)
    );

    assign {clk_s, ser_s, par_s, dir_s, as_s, a_en_s, a_s, b_s} = pins_s;

    assign mode = bbsr_pkg::bbsr_decode_mode(par_s, as_s);

    // rising edge of the shift clock
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            clk_d_ff <= 1'b0;
        end else begin
            clk_d_ff <= clk_s;
        end
    end

    assign clocked  = (mode != bbsr_pkg::MODE_PAR_FOLLOW);
    assign edge_any = (clk_s && !clk_d_ff) || pend_ff;
    // a clocked update waits while the snapshot fifo is full
    assign go       = clocked && edge_any && fifo_ready;

    // held edge is dropped on entering follow mode so none leaks into serial
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= clocked && edge_any && !fifo_ready;
        end
    end

    // parallel source: B toward A, A toward B, or own value
    always_comb begin
        if (!dir_s) begin
            par_src = b_s;
        end else if (a_en_s) begin
            par_src = a_s;
        end else begin
            par_src = stage_ff;
        end
    end

    always_comb begin
        nxt_stage = stage_ff;
        unique case (mode)
            bbsr_pkg::MODE_SERIAL: begin
                if (go) begin
                    nxt_stage = {stage_ff[`BBSR_LAST_STAGE-1:0], ser_s};
                end
            end
            bbsr_pkg::MODE_PAR_CLOCKED: begin
                if (go) begin
                    nxt_stage = par_src;
                end
            end
            bbsr_pkg::MODE_PAR_FOLLOW: begin
                nxt_stage = par_src;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            stage_ff <= `BBSR_RESET_VAL;
        end else begin
            stage_ff <= nxt_stage;
        end
    end

    // side A driven only with enable high and direction low
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            a_oe_ff <= 1'b0;
            b_oe_ff <= 1'b0;
        end else begin
            a_oe_ff <= a_en_s && !dir_s;
            b_oe_ff <= dir_s;
        end
    end

    assign A_DATA_O  = stage_ff;
    assign B_DATA_O  = stage_ff;
    assign A_OE_O    = a_oe_ff;
    assign B_OE_O    = b_oe_ff;
    assign SER_OUT_O = stage_ff[`BBSR_LAST_STAGE];

    // each clocked update leaves a snapshot of the new contents
    bbsr_fifo #(
        .WIDTH       (`BBSR_WIDTH),
        .DEPTH       (`BBSR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_SYS_I),
        .reset_n_i   (RESET_N_I),
        .in_valid_i  (go),
        .in_ready_o  (fifo_ready),
        .in_data_i   (nxt_stage),
        .out_valid_o (SNAP_VALID_O),
        .out_ready_i (SNAP_READY_I),
        .out_data_o  (SNAP_DATA_O)
    );

    logic [`BBSR_WIDTH-1:0] chk_prev_ff;

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            chk_prev_ff <= `BBSR_RESET_VAL;
        end else begin
            chk_prev_ff <= stage_ff;
        end
    end

    chk_serial_shift: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!par_s && go)
        |=> (SER_OUT_O == chk_prev_ff[`BBSR_LAST_STAGE-1])
            && (A_DATA_O[`BBSR_LAST_STAGE:1] == chk_prev_ff[`BBSR_LAST_STAGE-1:0])
            && (A_DATA_O[0] == $past(ser_s))
    ) else $error("serial shift did not move the stages by one");

    chk_serial_idle: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!par_s && !go) |=> $stable(stage_ff)
    ) else $error("serial mode changed contents without a clock edge");

    chk_a_float: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!a_en_s || dir_s) |=> !A_OE_O
    ) else $error("side A driven while it should float");

    chk_a_drive: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (a_en_s && !dir_s) |=> A_OE_O && !B_OE_O
    ) else $error("side A not driven with enable high and direction low");

    chk_b_drive: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        dir_s ##1 dir_s |-> B_OE_O && !A_OE_O
    ) else $error("side B not driven with direction high");

    chk_clocked_b: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && !as_s && !dir_s && go) |=> B_DATA_O == $past(b_s)
    ) else $error("clocked load from side B missed");

    chk_follow_b: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && as_s && !dir_s) [*2] |=> A_DATA_O == $past(b_s)
    ) else $error("contents do not follow side B");

    chk_recirculate: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && dir_s && !a_en_s) |=> $stable(stage_ff)
    ) else $error("recirculating stages changed value");

    chk_clocked_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && !as_s && dir_s && a_en_s && go) |=> B_DATA_O == $past(a_s)
    ) else $error("clocked load from side A missed");

    chk_follow_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && as_s && dir_s && a_en_s) |=> B_DATA_O == $past(a_s)
    ) else $error("contents do not follow side A");

    chk_clocked_wait: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && !as_s && !go) |=> $stable(stage_ff)
    ) else $error("clocked parallel load without a clock edge");

    chk_edge_served: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (clk_s && !clk_d_ff && !as_s && fifo_ready) |-> go
    ) else $error("shift clock edge not taken with room in the fifo");

    chk_oe_exclusive: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !(A_OE_O && B_OE_O)
    ) else $error("both sides driven at once");

    chk_serial_float: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!par_s && !dir_s && !a_en_s) |=> !A_OE_O && !B_OE_O
    ) else $error("serial mode drove a side with direction and enable low");

    chk_serial_async: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!par_s && as_s && go) |=> (A_DATA_O[0] == $past(ser_s))
    ) else $error("serial shift disturbed by the async select");

    chk_serial_cascade: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!par_s && go) |=> (SER_OUT_O == $past(A_DATA_O[`BBSR_LAST_STAGE-1]))
    ) else $error("cascade output did not take the stage before it");

    chk_b_input: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !dir_s |=> !B_OE_O
    ) else $error("side B driven while it is the input");

    chk_par_b_float: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && !dir_s && !a_en_s) |=> !A_OE_O && !B_OE_O
    ) else $error("a side driven while loading B with A disabled");

    chk_a_ignored: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && !as_s && dir_s && !a_en_s && go) |=> (B_DATA_O == $past(B_DATA_O))
    ) else $error("clocked recirculation took side A");

    chk_follow_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && as_s && dir_s && !a_en_s) |=> (B_DATA_O == $past(B_DATA_O))
    ) else $error("follow recirculation changed the contents");

    chk_follow_quiet: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (par_s && as_s) |-> !go
    ) else $error("follow transfer made a clocked update");

    chk_update_snapshot: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        go |=> SNAP_VALID_O
    ) else $error("clocked update left no snapshot");

    chk_edge_kept: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (clk_s && !clk_d_ff && clocked && !fifo_ready) |=> pend_ff
    ) else $error("shift clock edge lost while the fifo was full");

    chk_pend_served: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (pend_ff && SNAP_READY_I && clocked) |-> ##[1:2] !pend_ff
    ) else $error("held shift clock edge not served after a pop");

endmodule
`default_nettype wire

// ===== bbsr_top_test.sv
// self-checking bench of the bidirectional bus shift register
`timescale 1ns/10ps
`default_nettype none
module bbsr_top_test;
    logic       clk = 0, rst_n = 0, sclk = 0, ser = 0, rdy = 1;
    logic       par = 0, dir = 0, asy = 0, en = 0;
    logic [7:0] a_ext = 8'h00, b_ext = 8'h00;
    logic [7:0] a_bus, b_bus, a_do, b_do, snap, v;
    logic       a_oe, b_oe, sout, svld;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, tests_run = 0, cyc = 0, seed = 85, st = 0, k;

    always #4 clk = ~clk;

    bbsr_top dut (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .SHIFT_CLK_I(sclk), .SER_DATA_I(ser),
        .PAR_SER_SEL_I(par), .DIR_SEL_I(dir), .ASYNC_SEL_I(asy), .SIDE_A_DRIVE_ENABLE_I(en),
        .A_DATA_I(a_bus), .A_DATA_O(a_do), .A_OE_O(a_oe), .B_DATA_I(b_bus), .B_DATA_O(b_do),
        .B_OE_O(b_oe), .SER_OUT_O(sout), .SNAP_DATA_O(snap), .SNAP_VALID_O(svld),
        .SNAP_READY_I(rdy)
    );

    bbsr_bus_model far (
        .a_oe_i(a_oe), .a_dev_i(a_do), .a_ext_i(a_ext),
        .b_oe_i(b_oe), .b_dev_i(b_do), .b_ext_i(b_ext),
        .a_bus_o(a_bus), .b_bus_o(b_bus)
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_out;
        chk("stage a", st[7:0], a_do);
        chk("stage b", st[7:0], b_do);
        chk("serial out", {7'h00, st[7]}, {7'h00, sout});
        chk("a enable", {7'h00, en & ~dir}, {7'h00, a_oe});
        chk("b enable", {7'h00, dir}, {7'h00, b_oe});
    endtask

    task automatic ctl(input logic p, input logic d, input logic a, input logic e);
        @(posedge clk);
        par <= p;
        dir <= d;
        asy <= a;
        en <= e;
        wait_n(5);
    endtask

    // one shift clock pulse; the expected snapshot is queued
    task automatic pulse(input logic s, input int nxt);
        exp_q.push_back(nxt[7:0]);
        @(posedge clk);
        ser <= s;
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
        sclk <= 1'b0;
        wait_n(4);
    endtask

    function automatic int src();
        return dir ? (en ? int'(a_ext) : st) : int'(b_ext);
    endfunction

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_n && svld === 1'b1 && rdy) begin
            if (exp_q.size() == 0) begin
                chk("snapshot", 8'h00, 8'hff);
            end else begin
                chk("snapshot", exp_q.pop_front(), snap);
            end
        end
        if (cyc > 5000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wait_n(3);
        chk_out();
        $display("reset test done");
        for (k = 0; k < 12; k++) begin
            v = 8'($random(seed));
            ctl(1'b0, k[1], v[3], k[0]);
            pulse(v[0], ((st << 1) | v[0]) & 255);
            st = ((st << 1) | v[0]) & 255;
            chk_out();
        end
        $display("serial test done");
        for (k = 0; k < 8; k++) begin
            ctl(1'b1, k[1], k[0], k[2]);
            if (k[0]) st = src();
            repeat (2) begin
                v = 8'($random(seed));
                @(posedge clk);
                a_ext <= v;
                b_ext <= ~v;
                wait_n(5);
                if (k[0]) begin
                    st = src();
                end else begin
                    pulse(1'b1, src());
                    st = src();
                end
                chk_out();
            end
        end
        ctl(1'b1, 1'b1, 1'b0, 1'b1);
        ctl(1'b0, 1'b0, 1'b0, 1'b1);
        chk_out();
        $display("parallel test done");
        @(posedge clk);
        rdy <= 1'b0;
        for (k = 0; k < 17; k++) begin
            v = 8'($random(seed));
            pulse(v[0], ((st << 1) | v[0]) & 255);
            if (k < 16) st = ((st << 1) | v[0]) & 255;
            chk_out();
        end
        chk("snap valid", 8'h01, {7'h00, svld});
        @(posedge clk);
        rdy <= 1'b1;
        st = ((st << 1) | v[0]) & 255;
        wait_n(8);
        chk_out();
        wait_n(20);
        chk("snap valid", 8'h00, {7'h00, svld});
        $display("buffer test done");
        summarize();
    end
endmodule
`default_nettype wire
